// ---- hdl/bias_ctl_pkg.sv ----
// What this block does
// - With run high, each step rising edge advances the set-point counter by one.
// - Counter has 64 steps spanning 33% to 100% of full-scale output.
// - Advancing past full scale wraps to minimum; 63 advances lower by one.
// - Power-up or reset loads the counter with mid-range.
// - Mid-scale is 32 steps above minimum and 31 below maximum.
// - Step high with run low resets counter to mid-scale; converter stays active.
// - Step low and run low enters shutdown; switch stops.
// - Shutdown keeps the counter value and restores it on leaving shutdown.
// - While step is low, counter never changes whatever run does.
// - Run high means converter on, whatever the step level.
// - Shutdown disables reference and bias so the output falls to zero.
// - Maximum on-time one-shot forces the switch off 8 us after turn-on.
// - Current-sense comparator trip ends the on-phase.
// - After each turn-off the switch stays off at least 1 us.
// - After minimum off-time, restart only if output is out of regulation.
// - Output counts as regulated when the feedback node sits at 0 V.
package bias_ctl_pkg;

  localparam int unsigned CODE_W       = 6;
  localparam logic [5:0]  CODE_MIN     = 6'h00;
  localparam logic [5:0]  CODE_MAX     = 6'h3F;
  localparam logic [5:0]  CODE_MID     = 6'h20;

  // Timing in nanoseconds and the clock rate they are counted at.
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned MAX_ON_NS     = 8000;
  localparam int unsigned MIN_OFF_NS    = 1000;
  localparam int unsigned TMR_W         = 9;
  // Longest time rounds down; least time rounds up.
  localparam logic [8:0]  MAX_ON_CYC    = 9'(MAX_ON_NS / CLK_PERIOD_NS);
  localparam logic [8:0]  MIN_OFF_CYC   = 9'((MIN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {MODE_SHUTDOWN, MODE_RESET, MODE_ON} mode_t;
  typedef enum logic [1:0] {SW_OFF_HOLD, SW_IDLE, SW_ON} sw_state_t;

endpackage

// ---- hdl/switch_timer_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// Request and status between the switch sequencer and its one-shot timer.
interface switch_timer_if;
  logic       start_on;
  logic       start_off;
  logic       on_expired;
  logic       off_expired;
  modport owner (output start_on, output start_off, input on_expired, input off_expired);
  modport timer (input start_on, input start_off, output on_expired, output off_expired);
endinterface
`default_nettype wire

// ---- hdl/switch_one_shot.sv ----
`timescale 1ns/1ps
`default_nettype none
module switch_one_shot
  import bias_ctl_pkg::*;
(
  // Clock and reset.
  input  wire logic          clk,
  input  wire logic          rst,
  // Sequencer side.
  switch_timer_if.timer      tmr
);

  logic [TMR_W-1:0] count_r;
  logic             on_phase_r;

  ////////////////////////////////////////////////////////////////////////////
  // One counter serves both one-shots, since on and off phases never overlap.
  always_ff @(posedge clk or posedge rst)
  begin
    // Reset loads a full off-time so the sequencer's reset hold lasts one minimum off-time.
    if (rst)
    begin
      count_r    <= MIN_OFF_CYC;
      on_phase_r <= 1'b0;
    end
    else if (tmr.start_on)
    begin
      // One less, because the drive already stands on for the cycle at which zero is seen.
      count_r    <= MAX_ON_CYC - 9'h001;
      on_phase_r <= 1'b1;
    end
    else if (tmr.start_off)
    begin
      count_r    <= MIN_OFF_CYC;
      on_phase_r <= 1'b0;
    end
    else if (count_r != '0)
    begin
      count_r <= count_r - 1'b1;
    end
  end

  // Expiry flags hold while the count rests at zero.
  assign tmr.on_expired  = on_phase_r && (count_r == '0);
  assign tmr.off_expired = !on_phase_r && (count_r == '0);

endmodule
`default_nettype wire

// ---- hdl/bias_setpoint_counter_switch_ctl.sv ----
`timescale 1ns/1ps
`default_nettype none
module bias_setpoint_counter_switch_ctl
  import bias_ctl_pkg::*;
(
  // Clock and reset (reset stands in for power-up).
  input  wire logic              clk,
  input  wire logic              rst,
  // Host logic inputs, asynchronous to clk.
  input  wire logic              step_pulse_in,
  input  wire logic              run_in,
  // Analog comparator results, asynchronous to clk.
  input  wire logic              current_limit_in,
  input  wire logic              feedback_node,
  // Switch drive outputs.
  output logic                   switch_drive_high,
  output logic                   switch_drive_low,
  // Set point and bias state.
  output logic [CODE_W-1:0]      setpoint_code,
  output logic                   bias_enable,
  output logic                   shutdown
);

  // Synchronisers: stage one is read only by stage two.
  logic [1:0] step_sync_r;
  logic [1:0] run_sync_r;
  logic [1:0] ilim_sync_r;
  logic [1:0] fb_sync_r;
  logic       step_prev_r;
  logic       step_s;
  logic       run_s;
  logic       ilim_s;
  logic       fb_low_s;
  logic       step_rise;

  logic [CODE_W-1:0] code_r;
  logic [CODE_W-1:0] code_nxt;
  mode_t             mode_r;
  mode_t             mode_nxt;
  sw_state_t         sw_r;
  sw_state_t         sw_nxt;
  logic              drive_on_r;
  logic              bias_en_r;

  switch_timer_if tmr_bus();

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation.

  // Two flops on every pin input keep metastability away from the decode.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      step_sync_r <= 2'h0;
      run_sync_r  <= 2'h0;
      ilim_sync_r <= 2'h0;
      fb_sync_r   <= 2'h0;
    end
    else
    begin
      step_sync_r <= {step_sync_r[0], step_pulse_in};
      run_sync_r  <= {run_sync_r[0], run_in};
      ilim_sync_r <= {ilim_sync_r[0], current_limit_in};
      fb_sync_r   <= {fb_sync_r[0], feedback_node};
    end
  end

  assign step_s   = step_sync_r[1];
  assign run_s    = run_sync_r[1];
  assign ilim_s   = ilim_sync_r[1];
  // The comparator reports high while the feedback node is below 0 V.
  assign fb_low_s = fb_sync_r[1];

  // Edge memory starts low, so a step held high through reset counts as an edge once synchronised.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      step_prev_r <= 1'b0;
    end
    else
    begin
      step_prev_r <= step_s;
    end
  end

  assign step_rise = step_s && !step_prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // Control decode.

  // Run high always means on; step level then only matters for edges.
  always_comb
  begin
    if (run_s)
    begin
      mode_nxt = MODE_ON;
    end
    else if (step_s)
    begin
      mode_nxt = MODE_RESET;
    end
    else
    begin
      mode_nxt = MODE_SHUTDOWN;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mode_r <= MODE_ON;
    end
    else
    begin
      mode_r <= mode_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Set-point counter.

  // Six-bit arithmetic wraps 63 to 0 by itself, which is the intended rollover.
  always_comb
  begin
    code_nxt = code_r;
    if (run_s && step_rise)
    begin
      code_nxt = code_r + 6'h01;
    end
    else if (!run_s && step_s)
    begin
      code_nxt = CODE_MID;
    end
  end

  // Code 0 is the 33% minimum and code 63 full scale over 64 steps.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      code_r <= CODE_MID;
    end
    else
    begin
      code_r <= code_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference and bias enable.

  // Bias drops in shutdown so the output decays to zero; the code is kept.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bias_en_r <= 1'b0;
    end
    else
    begin
      bias_en_r <= (mode_nxt != MODE_SHUTDOWN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switch sequencer.

  // The sequencer starts in the off hold so no pulse fires straight out of reset.
  always_comb
  begin
    sw_nxt = sw_r;
    tmr_bus.start_on  = 1'b0;
    tmr_bus.start_off = 1'b0;
    unique case (sw_r)
      SW_ON:
      begin
        if (mode_r == MODE_SHUTDOWN || ilim_s || tmr_bus.on_expired)
        begin
          sw_nxt = SW_OFF_HOLD;
          tmr_bus.start_off = 1'b1;
        end
      end
      SW_OFF_HOLD:
      begin
        if (tmr_bus.off_expired)
        begin
          sw_nxt = SW_IDLE;
        end
      end
      SW_IDLE:
      begin
        // Restart only when regulation is lost and the converter is enabled.
        if (mode_r != MODE_SHUTDOWN && !fb_low_s)
        begin
          sw_nxt = SW_ON;
          tmr_bus.start_on = 1'b1;
        end
      end
    endcase
  end

  // The hold state also guards entry from reset with a full minimum off-time.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sw_r <= SW_OFF_HOLD;
    end
    else
    begin
      sw_r <= sw_nxt;
    end
  end

  // Drive registered from the next state so the pins follow the sequencer.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      drive_on_r <= 1'b0;
    end
    else
    begin
      drive_on_r <= (sw_nxt == SW_ON);
    end
  end

  switch_one_shot u_one_shot (
    .clk (clk),
    .rst (rst),
    .tmr (tmr_bus.timer)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flops.

  // A P-type switch conducts when its control node is pulled low.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      switch_drive_high <= 1'b1;
      switch_drive_low  <= 1'b1;
      setpoint_code     <= CODE_MID;
      bias_enable       <= 1'b0;
      shutdown          <= 1'b0;
    end
    else
    begin
      switch_drive_high <= !drive_on_r;
      switch_drive_low  <= !drive_on_r;
      setpoint_code     <= code_r;
      bias_enable       <= bias_en_r;
      shutdown          <= !bias_en_r;
    end
  end

endmodule
`default_nettype wire

// ---- testbench/bias_ctl_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module bias_ctl_props
  import bias_ctl_pkg::*;
(
  // Clock, reset and inputs.
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              step_pulse_in,
  input wire logic              run_in,
  input wire logic              current_limit_in,
  input wire logic              feedback_node,
  // Outputs.
  input wire logic              switch_drive_high,
  input wire logic [CODE_W-1:0] setpoint_code,
  input wire logic              bias_enable,
  input wire logic              shutdown
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic [8:0] on_r;
  logic [8:0] off_r;
  // Run lengths of each drive level; off starts full so reset is no short gap.
  always_ff @(posedge clk or posedge rst)
    if (rst)
      on_r <= 9'h000;
    else
      on_r <= switch_drive_high ? 9'h000 : on_r + 9'h001;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      off_r <= 9'h1FF;
    else
      off_r <= !switch_drive_high ? 9'h000 : off_r + {8'h00, ~&off_r};
  ////////////////////////////////////////////////////////////////////////////////
  max_on_a: assert property (on_r <= MAX_ON_CYC)
    else $error("on-phase too long");
  min_off_a: assert property ($fell(switch_drive_high) |-> off_r >= MIN_OFF_CYC)
    else $error("off gap too short");
  lim_trip_a: assert property (current_limit_in[*6] |-> switch_drive_high)
    else $error("limit ignored");
  reg_hold_a: assert property (feedback_node[*5] ##0 switch_drive_high |=> switch_drive_high)
    else $error("turned on in regulation");
  code_hold_a: assert property (!step_pulse_in[*6] |-> $stable(setpoint_code))
    else $error("code moved");
  code_step_a: assert property (setpoint_code != $past(setpoint_code) |->
    setpoint_code == $past(setpoint_code) + 6'h01 || setpoint_code == CODE_MID)
    else $error("bad code step");
  run_on_a: assert property (run_in[*6] |-> bias_enable && !shutdown)
    else $error("off while run high");
  sd_stop_a: assert property ((!run_in && !step_pulse_in)[*6] |-> shutdown && switch_drive_high)
    else $error("no shutdown");
  bias_pair_a: assert property (!$past(rst, 2) |-> bias_enable != shutdown)
    else $error("bias and shutdown agree");
  cover property ($rose(shutdown));
  cover property (on_r == MAX_ON_CYC);
  cover property (current_limit_in && !switch_drive_high);
endmodule
bind bias_setpoint_counter_switch_ctl bias_ctl_props chk_u (.clk(clk), .rst(rst),
  .step_pulse_in(step_pulse_in), .run_in(run_in), .current_limit_in(current_limit_in),
  .feedback_node(feedback_node), .switch_drive_high(switch_drive_high),
  .setpoint_code(setpoint_code), .bias_enable(bias_enable), .shutdown(shutdown));
`default_nettype wire

// ---- testbench/host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock and host lines.
  input  wire logic clk,
  output logic      step_pulse_in,
  output logic      run_in
);
  // Both lines low at start, as a host that has not yet driven them.
  initial
  begin
    step_pulse_in = 1'b0;
    run_in        = 1'b0;
  end
  // Level change just after an edge.
  task automatic mode(input logic s, input logic r);
    @(posedge clk);
    step_pulse_in <= s;
    run_in        <= r;
  endtask
  // Three cycles high and low, so the synchroniser never misses an edge.
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge clk);
      step_pulse_in <= 1'b1;
      repeat (3) @(posedge clk);
      step_pulse_in <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb
  import bias_ctl_pkg::*;
();
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              lim = 1'b0;
  logic              fb  = 1'b1;
  logic              stp;
  logic              run;
  logic              dh;
  logic              dl;
  logic              ben;
  logic              sd;
  logic [CODE_W-1:0] code;
  int                fails = 0;
  int                compares = 0;
  int                n;
  always #10 clk = ~clk;
  host_model h (.clk(clk), .step_pulse_in(stp), .run_in(run));
  bias_setpoint_counter_switch_ctl dut_u (.clk(clk), .rst(rst), .step_pulse_in(stp),
    .run_in(run), .current_limit_in(lim), .feedback_node(fb), .switch_drive_high(dh),
    .switch_drive_low(dl), .setpoint_code(code), .bias_enable(ben), .shutdown(sd));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // Waits are bounded; a hang counts as a mismatch and ends the run.
  task automatic wait_dh(input logic lv, input int bound);
    n = 0;
    while (dh !== lv)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n > bound)
      begin
        chk(dh, lv);
        give_verdict;
      end
    end
  endtask
  task automatic go(input logic s, input logic r);
    h.mode(s, r);
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic cnt(input int k, input logic [7:0] e);
    h.pulse(k);
    repeat (6) @(posedge clk);
    #1;
    chk(code, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_modes;
    go(1'b0, 1'b0);
    chk(sd, 1'b1);
    chk(ben, 1'b0);
    chk(code, 8'h3F);
    h.mode(1'b0, 1'b1);
    go(1'b0, 1'b0);
    chk(code, 8'h3F);
    go(1'b0, 1'b1);
    chk(ben, 1'b1);
    go(1'b1, 1'b0);
    chk(code, CODE_MID);
    chk(sd, 1'b0);
    go(1'b1, 1'b1);
    chk(ben, 1'b1);
    go(1'b0, 1'b1);
  endtask
  task automatic t_switch;
    fb <= 1'b0;
    wait_dh(1'b0, 20);
    wait_dh(1'b1, 420);
    chk(n <= MAX_ON_CYC && n >= MAX_ON_CYC - 2, 1'b1);
    wait_dh(1'b0, 80);
    chk(n >= MIN_OFF_CYC, 1'b1);
    chk(dl, dh);
    lim <= 1'b1;
    fb  <= 1'b1;
    wait_dh(1'b1, 6);
    repeat (4) @(posedge clk);
    lim <= 1'b0;
    repeat (100) @(posedge clk);
    #1;
    chk(dh, 1'b1);
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(code, CODE_MID);
    chk(dh, 1'b1);
    h.mode(1'b0, 1'b1);
    cnt(1, 8'h21);
    cnt(30, 8'h3F);
    cnt(1, 8'h00);
    cnt(63, 8'h3F);
    t_modes;
    t_switch;
    give_verdict;
  end
endmodule
`default_nettype wire
